// ### rtl/vfdreg_pkg.sv
/*
 * Shared constants of the display controller register bank: command
 * addresses, field positions, reset values and multiplex timing.
 * Assumes a 100 MHz core clock from which the multiplex oscillator is derived.
 */
package vfdreg_pkg;

    // command addresses (seven-bit)
    localparam logic [6:0] ADDR_INTENSITY  = 7'h02;
    localparam logic [6:0] ADDR_GRID_COUNT = 7'h03;
    localparam logic [6:0] ADDR_CONFIG     = 7'h04;
    localparam logic [6:0] ADDR_FONT       = 7'h05;
    localparam logic [6:0] ADDR_CURSOR     = 7'h0f;
    localparam logic [6:0] ADDR_ANN_BASE   = 7'h20;
    localparam int         ANN_BYTES       = 4;

    // serial frame layout
    localparam int FRAME_BITS = 16;
    localparam int FRAME_RW   = 15;
    localparam int FRAME_ADDR = 8;

    // configuration fields
    localparam int CFG_RUN    = 0;
    localparam int CFG_LOCK   = 1;
    localparam int CFG_FAST   = 2;
    localparam int CFG_SYNC   = 4;
    localparam int CFG_CLEAR  = 5;
    localparam int CFG_MODE96 = 6;
    localparam int CFG_PHASE  = 7;

    // cursor fields
    localparam int CUR_BLINK   = 7;
    localparam int CUR_HIDE_HI = 6;
    localparam int CUR_HIDE_LO = 5;

    // font pointer window
    localparam logic [7:0] FONT_PTR_FIRST = 8'h80;
    localparam logic [7:0] FONT_PTR_LAST  = 8'hf7;
    localparam logic [7:0] FONT_PTR_DONE  = 8'hf8;
    localparam int         FONT_DEPTH     = 120;
    localparam int         FONT_WIDTH     = 7;

    // reset values and top intensity code
    localparam logic [3:0] INTENSITY_RST = 4'h0;
    localparam logic [5:0] GRID_RST      = 6'h00;
    localparam logic [7:0] CURSOR_RST    = 8'h60;
    localparam logic [3:0] INTENS_TOP    = 4'he;

    // multiplex timing
    localparam longint CORE_CLK_HZ      = 100_000_000;
    localparam longint OSC_HZ           = 4_000_000;
    localparam int     OSC_DIV          = int'(CORE_CLK_HZ / OSC_HZ);
    localparam real    SLOT_US          = 6.25;
    localparam int     SLOT_OSC         = int'(SLOT_US * real'(OSC_HZ) / 1.0e6);
    localparam int     DIGIT_PERIOD_OSC = 400;
    localparam int     SLOTS            = DIGIT_PERIOD_OSC / SLOT_OSC;
    localparam real    BLINK_SLOW_S     = 1.0;
    localparam real    BLINK_FAST_S     = 0.5;
    localparam int     BLINK_SLOW_OSC   = int'(BLINK_SLOW_S * real'(OSC_HZ));
    localparam int     BLINK_FAST_OSC   = int'(BLINK_FAST_S * real'(OSC_HZ));

endpackage

// ### rtl/vfdreg_font_mem.sv
/*
 * User glyph store: one seven-bit word per font pointer location.
 * Assumes one access per cycle; read data appear one cycle after rd_en_i.
 */
`timescale 1ns/100ps
module vfdreg_font_mem #(
    parameter int DEPTH = 120,
    parameter int WIDTH = 7
) (
    // clock
    input  wire logic                     clk_i,
    // write port
    input  wire logic                     wr_en_i,
    input  wire logic [$clog2(DEPTH)-1:0] wr_addr_i,
    input  wire logic [WIDTH-1:0]         wr_data_i,
    // read port
    input  wire logic                     rd_en_i,
    input  wire logic [$clog2(DEPTH)-1:0] rd_addr_i,
    output logic      [WIDTH-1:0]         rd_data_o
);
    logic [WIDTH-1:0] mem_r [DEPTH];

    always_ff @(posedge clk_i) begin
        if (wr_en_i) begin
            mem_r[wr_addr_i] <= wr_data_i;
        end
        if (rd_en_i) begin
            rd_data_o <= mem_r[rd_addr_i];
        end
    end
endmodule

// ### rtl/vfdreg_bank.sv
/*
 * Register bank of a multiplexed matrix display controller behind a
 * 16-bit serial link, with blink timer and intensity blanking generator.
 * Assumes the link clock stands still outside frames, chip select is low
 * for exactly one 16-bit frame, and read data return in the next frame.
 */
// Function
// (RQ1) font data write stores seven bits at pointer, then pointer advances
// (RQ2) cursor bits 6..0 pick digit; bits 6 and 5 both set hide cursor
// (RQ3) cursor bit 7 clear lights steadily, set lights first blink half only
// (RQ4) annunciator field: 00 off, 01 first half, 10 second half, 11 on
// (RQ5) four annunciator fields sit at bits 1..0, 3..2, 5..4, 7..6
// (RQ6) configuration bit 0: 0 shutdown, 1 normal operation
// (RQ7) configuration bit 1 holds lock state, 1 locked
// (RQ8) configuration bit 2 picks slow one-second or fast half-second blink
// (RQ9) configuration bit 4 clears blink counters at chip-select rising edge
// (RQ10) configuration bit 5 clears annunciator data at chip-select rising edge
// (RQ11) configuration bit 6 picks 48 single or 96 paired digits
// (RQ12) configuration bit 7 reads current blink phase
// (RQ13) frame is 16 bits: read flag, seven-bit address, data MSB first
// (RQ14) grid count N drives N+1 grids, legal up to 0x2F
// (RQ15) blanking high one slot, low n+1 slots, then high
// (RQ16) intensity codes 0xE and 0xF both give fifteen-sixteenths on-time
// (RQ17) digit period is 400 oscillator cycles, sixteen 25-cycle slots
// (RQ18) font read returns entry with bit 7 clear, advances; write >=0x80 loads pointer
// (RQ19) pointer advances within 0x80..0xF6; stops after 0xF7; >=0xF8 forces 0x80
// (RQ20) configuration bit 3 ignored on write, reads zero
// (RQ21) one blink counter serves cursor, annunciators and phase readback
`timescale 1ns/100ps
module vfdreg_bank #(
    parameter int ANN_BYTES  = vfdreg_pkg::ANN_BYTES,
    parameter int BLINK_SLOW = vfdreg_pkg::BLINK_SLOW_OSC,
    parameter int BLINK_FAST = vfdreg_pkg::BLINK_FAST_OSC
) (
    // core clock and reset
    input  wire logic                   core_clk_i,
    input  wire logic                   rst_i,
    // serial link
    input  wire logic                   link_sclk_i,
    input  wire logic                   link_cs_n_i,
    input  wire logic                   link_din_i,
    output logic                        link_dout_o,
    // display control
    output logic                        tube_blanking_out_o,
    output logic [6:0]                  cursor_pos_o,
    output logic                        cursor_on_o,
    output logic [ANN_BYTES*4-1:0]      ann_lit_o,
    output logic                        first_blink_half_o,
    output logic                        shutdown_o,
    output logic                        lock_o,
    output logic                        mode_96_o,
    output logic [5:0]                  grid_count_o
);
    localparam int BW = $clog2(BLINK_SLOW + 1);
    localparam int FW = $clog2(vfdreg_pkg::FONT_DEPTH);

    typedef enum logic [0:0] {ST_IDLE, ST_FONT_WAIT} vfdreg_st_type;

    typedef struct packed {
        logic                   tog_s1;
        logic                   tog_s2;
        logic                   tog_s3;
        logic                   cs_s1;
        logic                   cs_s2;
        logic                   cs_s3;
        logic [4:0]             osc_div;
        logic [4:0]             sub;
        logic [3:0]             slot;
        logic [BW-1:0]          blink_cnt;
        logic                   blink_ph;
        logic [3:0]             intensity;
        logic [5:0]             grids;
        logic [7:0]             cursor;
        logic                   cfg_run;
        logic                   cfg_lock;
        logic                   cfg_fast;
        logic                   cfg_mode96;
        logic                   pend_sync;
        logic                   pend_clr;
        logic [ANN_BYTES*8-1:0] ann;
        logic [7:0]             font_ptr;
        vfdreg_st_type          st;
        logic [15:0]            rd_word;
        logic                   blank;
    } vfdreg_core_type;

    typedef struct packed {
        logic [3:0]  cnt;
        logic [14:0] sr;
    } vfdreg_shift_type;

    typedef struct packed {
        logic [15:0] word;
        logic        tog;
    } vfdreg_word_type;

    vfdreg_core_type  q_r, q_nxt;
    vfdreg_shift_type sh_r, sh_nxt;
    vfdreg_word_type  lw_r, lw_nxt;

    // link domain: shift in, cleared by the frame's own chip select
    always_comb begin
        sh_nxt = sh_r;
        lw_nxt = lw_r;
        sh_nxt.sr  = {sh_r.sr[13:0], link_din_i};
        sh_nxt.cnt = sh_r.cnt + 4'h1;
        if (sh_r.cnt == 4'(vfdreg_pkg::FRAME_BITS - 1)) begin
            lw_nxt.word = {sh_r.sr, link_din_i};  // see (RQ13)
            lw_nxt.tog  = ~lw_r.tog;
        end
    end

    always_ff @(posedge link_sclk_i or posedge link_cs_n_i) begin
        if (link_cs_n_i) begin
            sh_r <= '0;
        end else begin
            sh_r <= sh_nxt;
        end
    end

    // word and toggle survive chip select; link clock may never run before reset
    always_ff @(posedge link_sclk_i or posedge rst_i) begin
        if (rst_i) begin
            lw_r <= '0;
        end else begin
            lw_r <= lw_nxt;
        end
    end

    // read word is stable between frames, so it is safe to shift out here
    assign link_dout_o = link_cs_n_i ? 1'b0 : q_r.rd_word[4'hf - sh_r.cnt];  // see (RQ13)

    // font store
    logic           mem_wr;
    logic           mem_rd;
    logic [FW-1:0]  mem_addr;
    logic [6:0]     mem_rdata;
    logic [7:0]     frame_data;

    vfdreg_font_mem #(
        .DEPTH (vfdreg_pkg::FONT_DEPTH),
        .WIDTH (vfdreg_pkg::FONT_WIDTH)
    ) u_font (
        .clk_i     (core_clk_i),
        .wr_en_i   (mem_wr),
        .wr_addr_i (mem_addr),
        .wr_data_i (frame_data[6:0]),
        .rd_en_i   (mem_rd),
        .rd_addr_i (mem_addr),
        .rd_data_o (mem_rdata)
    );

    // core domain decode
    logic          new_word;
    logic          cs_rise;
    logic          frame_rd;
    logic [6:0]    frame_addr;
    logic          tick;
    logic          ptr_live;
    logic [3:0]    eff_code;
    logic [4:0]    low_end;
    logic [BW-1:0] half_len;
    logic [7:0]    cfg_read;
    logic [6:0]    ann_idx;

    assign new_word   = q_r.tog_s2 != q_r.tog_s3;
    assign cs_rise    = q_r.cs_s2 & ~q_r.cs_s3;
    assign frame_rd   = lw_r.word[vfdreg_pkg::FRAME_RW];
    assign frame_addr = lw_r.word[vfdreg_pkg::FRAME_RW-1:vfdreg_pkg::FRAME_ADDR];
    assign frame_data = lw_r.word[7:0];
    assign tick       = q_r.osc_div == 5'(vfdreg_pkg::OSC_DIV - 1);
    assign ptr_live   = q_r.font_ptr <= vfdreg_pkg::FONT_PTR_LAST;
    assign mem_addr   = FW'(q_r.font_ptr - vfdreg_pkg::FONT_PTR_FIRST);
    assign ann_idx    = frame_addr - vfdreg_pkg::ADDR_ANN_BASE;
    // codes above 0xE saturate at the top on-time
    assign eff_code   = (q_r.intensity > vfdreg_pkg::INTENS_TOP) ? vfdreg_pkg::INTENS_TOP : q_r.intensity;  // see (RQ16)
    assign low_end    = {1'b0, eff_code} + 5'h01;
    assign half_len   = q_r.cfg_fast ? BW'(BLINK_FAST) : BW'(BLINK_SLOW);  // see (RQ8)
    assign cfg_read   = {q_r.blink_ph, q_r.cfg_mode96, 1'b0, 1'b0, 1'b0,  // see (RQ12) (RQ20)
                         q_r.cfg_fast, q_r.cfg_lock, q_r.cfg_run};

    assign mem_wr = new_word & ~frame_rd & (frame_addr == vfdreg_pkg::ADDR_FONT)
                    & ~frame_data[7] & ptr_live & (q_r.st == ST_IDLE);
    assign mem_rd = new_word & frame_rd & (frame_addr == vfdreg_pkg::ADDR_FONT)
                    & ptr_live & (q_r.st == ST_IDLE);

    always_comb begin
        q_nxt = q_r;
        q_nxt.tog_s1 = lw_r.tog;
        q_nxt.tog_s2 = q_r.tog_s1;
        q_nxt.tog_s3 = q_r.tog_s2;
        q_nxt.cs_s1  = link_cs_n_i;
        q_nxt.cs_s2  = q_r.cs_s1;
        q_nxt.cs_s3  = q_r.cs_s2;

        // multiplex oscillator and slot counters
        q_nxt.osc_div = tick ? 5'h00 : q_r.osc_div + 5'h01;
        if (tick) begin
            if (q_r.sub == 5'(vfdreg_pkg::SLOT_OSC - 1)) begin  // see (RQ17)
                q_nxt.sub  = 5'h00;
                q_nxt.slot = q_r.slot + 4'h1;
            end else begin
                q_nxt.sub = q_r.sub + 5'h01;
            end
            if (q_r.blink_cnt >= half_len - BW'(1)) begin  // see (RQ21)
                q_nxt.blink_cnt = '0;
                q_nxt.blink_ph  = ~q_r.blink_ph;
            end else begin
                q_nxt.blink_cnt = q_r.blink_cnt + BW'(1);
            end
        end

        // blanking: high in slot 0, low for n+1 slots, high after
        if (!q_r.cfg_run || q_r.slot == 4'h0) begin  // see (RQ6) (RQ15)
            q_nxt.blank = 1'b1;
        end else if ({1'b0, q_r.slot} <= low_end) begin  // see (RQ15) (RQ16)
            q_nxt.blank = 1'b0;
        end else begin
            q_nxt.blank = 1'b1;
        end

        // deferred font read result
        case (q_r.st)
            ST_FONT_WAIT: begin
                q_nxt.rd_word = {8'h00, 1'b0, mem_rdata};  // see (RQ18)
                q_nxt.st      = ST_IDLE;
            end
            default: begin
                q_nxt.st = ST_IDLE;
            end
        endcase

        if (new_word && q_r.st == ST_IDLE) begin
            if (!frame_rd) begin
                if (frame_addr == vfdreg_pkg::ADDR_INTENSITY) begin
                    q_nxt.intensity = frame_data[3:0];  // see (RQ15)
                end else if (frame_addr == vfdreg_pkg::ADDR_GRID_COUNT) begin
                    q_nxt.grids = frame_data[5:0];  // see (RQ14)
                end else if (frame_addr == vfdreg_pkg::ADDR_FONT) begin
                    if (frame_data[7]) begin
                        q_nxt.font_ptr = (frame_data >= vfdreg_pkg::FONT_PTR_DONE)  // see (RQ19)
                                         ? vfdreg_pkg::FONT_PTR_FIRST : frame_data;  // see (RQ18)
                    end else if (ptr_live) begin
                        q_nxt.font_ptr = q_r.font_ptr + 8'h01;  // see (RQ1) (RQ19)
                    end
                end else if (frame_addr == vfdreg_pkg::ADDR_CURSOR) begin
                    q_nxt.cursor = frame_data;  // see (RQ2) (RQ3)
                end else if (frame_addr == vfdreg_pkg::ADDR_CONFIG) begin
                    q_nxt.cfg_run    = frame_data[vfdreg_pkg::CFG_RUN];  // see (RQ6)
                    q_nxt.cfg_lock   = frame_data[vfdreg_pkg::CFG_LOCK];  // see (RQ7)
                    q_nxt.cfg_fast   = frame_data[vfdreg_pkg::CFG_FAST];  // see (RQ8)
                    q_nxt.cfg_mode96 = frame_data[vfdreg_pkg::CFG_MODE96];  // see (RQ11)
                    q_nxt.pend_sync  = frame_data[vfdreg_pkg::CFG_SYNC];  // see (RQ9)
                    q_nxt.pend_clr   = frame_data[vfdreg_pkg::CFG_CLEAR];  // see (RQ10)
                end else if (frame_addr >= vfdreg_pkg::ADDR_ANN_BASE && ann_idx < 7'(ANN_BYTES)) begin
                    q_nxt.ann[ann_idx[$clog2(ANN_BYTES)-1:0]*8 +: 8] = frame_data;  // see (RQ5)
                end
            end else begin
                if (frame_addr == vfdreg_pkg::ADDR_INTENSITY) begin
                    q_nxt.rd_word = {12'h000, q_r.intensity};
                end else if (frame_addr == vfdreg_pkg::ADDR_GRID_COUNT) begin
                    q_nxt.rd_word = {10'h000, q_r.grids};  // see (RQ14)
                end else if (frame_addr == vfdreg_pkg::ADDR_FONT) begin
                    if (ptr_live) begin
                        q_nxt.st       = ST_FONT_WAIT;
                        q_nxt.font_ptr = q_r.font_ptr + 8'h01;  // see (RQ18) (RQ19)
                    end else begin
                        q_nxt.rd_word = 16'h0000;
                    end
                end else if (frame_addr == vfdreg_pkg::ADDR_CURSOR) begin
                    q_nxt.rd_word = {8'h00, q_r.cursor};
                end else if (frame_addr == vfdreg_pkg::ADDR_CONFIG) begin
                    q_nxt.rd_word = {8'h00, cfg_read};  // see (RQ12) (RQ20)
                end else if (frame_addr >= vfdreg_pkg::ADDR_ANN_BASE && ann_idx < 7'(ANN_BYTES)) begin
                    q_nxt.rd_word = {8'h00, q_r.ann[ann_idx[$clog2(ANN_BYTES)-1:0]*8 +: 8]};
                end else begin
                    q_nxt.rd_word = 16'h0000;
                end
            end
        end

        // chip-select end of access applies one-shot actions
        if (cs_rise) begin
            if (q_nxt.pend_sync) begin
                q_nxt.blink_cnt = '0;  // see (RQ9)
                q_nxt.blink_ph  = 1'b0;
            end
            if (q_nxt.pend_clr) begin
                q_nxt.ann = '0;  // see (RQ10)
            end
            q_nxt.pend_sync = 1'b0;
            q_nxt.pend_clr  = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            q_r            <= '0;
            q_r.cs_s1      <= 1'b1;
            q_r.cs_s2      <= 1'b1;
            q_r.cs_s3      <= 1'b1;
            q_r.intensity  <= vfdreg_pkg::INTENSITY_RST;
            q_r.grids      <= vfdreg_pkg::GRID_RST;
            q_r.cursor     <= vfdreg_pkg::CURSOR_RST;
            q_r.font_ptr   <= vfdreg_pkg::FONT_PTR_FIRST;
            q_r.st         <= ST_IDLE;
            q_r.blank      <= 1'b1;
        end else begin
            q_r <= q_nxt;
        end
    end

    // display-facing outputs
    logic cursor_hidden;
    assign cursor_hidden = q_r.cursor[vfdreg_pkg::CUR_HIDE_HI] & q_r.cursor[vfdreg_pkg::CUR_HIDE_LO];
    assign cursor_pos_o  = q_r.cursor[6:0];
    assign cursor_on_o   = q_r.cfg_run & ~cursor_hidden  // see (RQ2)
                           & (~q_r.cursor[vfdreg_pkg::CUR_BLINK] | ~q_r.blink_ph);  // see (RQ3)

    genvar gi;
    generate
        for (gi = 0; gi < ANN_BYTES * 4; gi++) begin : g_ann
            logic [1:0] fld;
            assign fld = q_r.ann[gi*2 +: 2];  // see (RQ5)
            assign ann_lit_o[gi] = q_r.cfg_run & ((fld == 2'b11)  // see (RQ4)
                                   | (fld == 2'b01 & ~q_r.blink_ph)
                                   | (fld == 2'b10 & q_r.blink_ph));
        end
    endgenerate

    assign tube_blanking_out_o = q_r.blank;
    assign first_blink_half_o  = ~q_r.blink_ph;
    assign shutdown_o          = ~q_r.cfg_run;
    assign lock_o              = q_r.cfg_lock;
    assign mode_96_o           = q_r.cfg_mode96;
    assign grid_count_o        = q_r.grids;

    // checks
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    a_blank_first_slot: assert property (q_r.cfg_run && q_r.slot == 4'h0 |=> tube_blanking_out_o)  // see (RQ15)
        else $error("blanking low in first slot");
    a_blank_on_slots: assert property (q_r.cfg_run && q_r.slot != 4'h0 && {1'b0, q_r.slot} <= low_end
                                       |=> !tube_blanking_out_o)  // see (RQ15)
        else $error("blanking high inside on-time");
    a_blank_max_code: assert property (q_r.cfg_run && q_r.intensity >= 4'he && q_r.slot == 4'hf
                                       |=> !tube_blanking_out_o)  // see (RQ16)
        else $error("top code lost last slot");
    a_slot_wrap: assert property (tick && q_r.slot == 4'hf && q_r.sub == 5'h18 |=> q_r.slot == 4'h0)  // see (RQ17)
        else $error("digit period length wrong");
    a_font_advance: assert property (mem_wr |=> q_r.font_ptr == $past(q_r.font_ptr) + 8'h01)  // see (RQ1)
        else $error("font pointer did not advance");
    a_font_reload: assert property (new_word && !frame_rd && frame_addr == vfdreg_pkg::ADDR_FONT
                                    && q_r.st == ST_IDLE && frame_data >= 8'hf8
                                    |=> q_r.font_ptr == 8'h80)  // see (RQ19)
        else $error("bad pointer not forced to base");
    a_font_read_data: assert property (mem_rd |=> ##1 q_r.rd_word[15:7] == 9'h000)  // see (RQ18)
        else $error("font read top bits set");
    a_cursor_hidden: assert property (cursor_hidden |-> !cursor_on_o)  // see (RQ2)
        else $error("hidden cursor lit");
    a_cursor_blink: assert property (q_r.cursor[7] && q_r.blink_ph |-> !cursor_on_o)  // see (RQ3)
        else $error("blinking cursor lit in second half");
    a_blink_sync: assert property (cs_rise && q_nxt.pend_sync |=> q_r.blink_cnt == '0 && !q_r.blink_ph)  // see (RQ9)
        else $error("blink counters not cleared");
    a_global_clear: assert property (cs_rise && q_nxt.pend_clr |=> q_r.ann == '0)  // see (RQ10)
        else $error("annunciator data not cleared");
    a_cfg_readback: assert property (new_word && frame_rd && frame_addr == vfdreg_pkg::ADDR_CONFIG
                                     && q_r.st == ST_IDLE
                                     |=> q_r.rd_word[3] == 1'b0 && q_r.rd_word[7] == $past(q_r.blink_ph))  // see (RQ12)
        else $error("configuration readback wrong");

    c_font_write: cover property (mem_wr ##[1:100] mem_wr);
    c_blink_flip: cover property (tick && q_r.blink_cnt == half_len - BW'(1));
    c_sync_clear: cover property (cs_rise && q_nxt.pend_sync);
    c_font_read: cover property (mem_rd);
endmodule

// ### test/vfdreg_host_model.sv
/* host model: sends one 16-bit frame per call on the serial link and captures dout.
   assumes the bench calls xfer only while the link is idle. */
`timescale 1ns/100ps
module vfdreg_host_model (
    // serial link
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      din_o,
    input  wire logic dout_i
);
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        din_o  = 1'b0;
    end

    // 6 ns clock runs only inside a frame; dout bit k is taken before rise k
    task automatic xfer(input logic [15:0] w, output logic [15:0] r);
        #1.7 cs_n_o = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            din_o = w[i];
            #3 r[i] = dout_i;
            sclk_o = 1'b1;
            #3 sclk_o = 1'b0;
        end
        #3 cs_n_o = 1'b1;
        din_o = ~din_o; // released line must not keep its last value
    endtask
endmodule

// ### test/tb.sv
/* bench of the register bank: frames from the host model, seeded random values,
   expectations worked out here. assumes blink counts shortened to 20/10 ticks. */
`timescale 1ns/100ps
module tb;
    logic             core_clk_i = 1'b0;
    logic             rst_i = 1'b1;
    wire logic        sclk, cs_n, din, dout, blank, cur_on, fh, shut, lock, m96;
    wire logic [6:0]  cur_pos;
    wire logic [15:0] ann;
    wire logic [5:0]  grid;
    logic      [15:0] rd;
    logic      [7:0]  v, d0, d1;
    int               fails = 0, num_checks = 0, cyc = 0, k;
    localparam int    BLINK_S = 20;
    localparam int    BLINK_F = 10;

    always #5 core_clk_i = ~core_clk_i;

    vfdreg_host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .dout_i(dout));
    vfdreg_bank #(.BLINK_SLOW(BLINK_S), .BLINK_FAST(BLINK_F)) DUT (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .link_sclk_i(sclk), .link_cs_n_i(cs_n),
        .link_din_i(din), .link_dout_o(dout), .tube_blanking_out_o(blank),
        .cursor_pos_o(cur_pos), .cursor_on_o(cur_on), .ann_lit_o(ann),
        .first_blink_half_o(fh), .shutdown_o(shut), .lock_o(lock), .mode_96_o(m96),
        .grid_count_o(grid));

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host.xfer({1'b0, a, d}, rd);
        repeat (12) @(negedge core_clk_i);
    endtask
    // read data come back in the following frame, a write to an unmapped place
    task automatic rdreg(input logic [6:0] a, output logic [7:0] d);
        host.xfer({1'b1, a, 8'h00}, rd);
        repeat (12) @(negedge core_clk_i);
        wr(7'h00, 8'h00);
        d = rd[7:0];
    endtask
    function automatic int low_cycles(input logic [3:0] c);
        return vfdreg_pkg::OSC_DIV * vfdreg_pkg::SLOT_OSC * ((c > 4'hd) ? 15 : int'(c) + 1);
    endfunction
    task automatic blank_len(output int n);
        n = 0;
        while (blank !== 1'b1 && n < 20000) begin @(negedge core_clk_i); n++; end
        while (blank !== 1'b0 && n < 40000) begin @(negedge core_clk_i); n++; end
        n = 0;
        while (blank === 1'b0 && n < 20000) begin @(negedge core_clk_i); n++; end
    endtask
    // one whole first blink half, measured from a phase edge
    task automatic blink_half(output int n);
        n = 0;
        while (fh !== 1'b0 && n < 2000) begin @(negedge core_clk_i); n++; end
        while (fh !== 1'b1 && n < 4000) begin @(negedge core_clk_i); n++; end
        n = 0;
        while (fh === 1'b1 && n < 2000) begin @(negedge core_clk_i); n++; end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // ceiling well above the roughly 33000 cycles of the sequence
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 95000) begin
            fails++;
            print_verdict();
        end
    end

    initial begin
        v = 8'($urandom(65050));
        repeat (6) @(posedge core_clk_i);
        rst_i <= 1'b0;
        repeat (4) @(negedge core_clk_i);
        chk("blank at reset", 16'h1, 16'(blank));
        wr(7'h04, 8'h4f);
        rdreg(7'h04, v);
        chk("config read", 16'h47, 16'(v[6:0]));
        chk("config out", 16'h3, {13'h0, shut, lock, m96});
        v = 8'($urandom_range(47));
        wr(7'h03, v);
        rdreg(7'h03, d0);
        chk("grid", {v, v}, {2'b00, grid, d0});
        $display("test config done");
        for (int i = 0; i < 3; i++) begin
            v = {4'($urandom), (i == 0) ? 4'($urandom_range(13)) : 4'(13 + i)};
            wr(7'h02, v);
            blank_len(k);
            chk("blank low", 16'(low_cycles(v[3:0])), 16'(k));
        end
        $display("test intensity done");
        d0 = 8'($urandom_range(127));
        d1 = 8'($urandom_range(127));
        wr(7'h05, 8'h80);
        wr(7'h05, d0);
        wr(7'h05, d1);
        wr(7'h05, 8'h80);
        rdreg(7'h05, v);
        chk("font 0", 16'(d0), 16'(v));
        rdreg(7'h05, v);
        chk("font 1", 16'(d1), 16'(v));
        wr(7'h05, 8'hf8 | 8'($urandom_range(7)));
        wr(7'h05, d1 ^ 8'h7f);
        wr(7'h05, 8'h80);
        rdreg(7'h05, v);
        chk("font wrap", 16'(d1 ^ 8'h7f), 16'(v));
        wr(7'h05, 8'hf7);
        wr(7'h05, d0);
        wr(7'h05, d0 ^ 8'h01);
        rdreg(7'h05, v);
        chk("font spent", 16'h0, 16'(v));
        wr(7'h05, 8'hf7);
        rdreg(7'h05, v);
        chk("font last", 16'(d0), 16'(v));
        $display("test font done");
        wr(7'h0f, 8'h5f);
        chk("cursor", 16'h00bf, 16'({cur_pos, cur_on}));
        wr(7'h0f, {3'b011, 5'($urandom)});
        chk("cursor hidden", 16'h0, 16'(cur_on));
        wr(7'h0f, 8'h85);
        wr(7'h20, 8'he4);
        repeat (8) begin
            repeat (37) @(negedge core_clk_i);
            chk("cursor blink", 16'(fh), 16'(cur_on));
            chk("ann", {12'h0, 1'b1, ~fh, fh, 1'b0}, ann);
        end
        $display("test blink done");
        wr(7'h04, 8'h17);
        chk("sync half", 16'h1, 16'(fh));
        rdreg(7'h04, v);
        chk("phase first", 16'h0, 16'(v[7]));
        k = 0;
        while (fh !== 1'b0 && k < 600) begin @(negedge core_clk_i); k++; end
        rdreg(7'h04, v);
        chk("phase second", 16'h1, 16'(v[7]));
        wr(7'h04, 8'h25);
        chk("ann clear", 16'h0, ann);
        blink_half(k);
        chk("fast half", 16'(BLINK_F * vfdreg_pkg::OSC_DIV), 16'(k));
        wr(7'h04, 8'h00);
        chk("shutdown", 16'h5, {13'h0, shut, cur_on, blank});
        blink_half(k);
        chk("slow half", 16'(BLINK_S * vfdreg_pkg::OSC_DIV), 16'(k));
        $display("test sync done");
        print_verdict();
    end
endmodule
